/* indirect_file_access_xor.v */
// data memory path with indirect window, banked pointer, port and xor unit
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`include "ifa_consts.vh"

//
// Contract
// - window access goes to pointer-addressed location
// - window read through zero pointer returns zero
// - window write to itself leaves the file unchanged, flags still move
// - pointer is five or seven bits wide
// - low pointer bits select address 00h-1Fh
// - unbanked: pointer bits six, five read one
// - banked: pointer bits six, five pick bank
// - bit set/clear rewrites all port bits
// - port written at end, read at start
// - xor literal into accumulator, zero flag only
// - xor file, d picks destination, zero only
module indirect_file_access_xor #(
    parameter BANKED = 1
) (
    input  wire        I_CLK_SYS,
    input  wire        I_RESETN,
    input  wire [4:0]  I_ADDRESS,
    input  wire        I_READ,
    input  wire        I_WRITE,
    input  wire [31:0] I_WRITEDATA,
    input  wire [3:0]  I_BYTEENABLE,
    output wire [31:0] O_READDATA,
    output wire        O_WAITREQUEST,
    input  wire [7:0]  I_PORT_PIN,
    output wire [7:0]  O_PORT_OUT,
    output wire [7:0]  O_PORT_OE
);

    localparam PTR_W = (BANKED != 0) ? 7 : 5;

    localparam [3:0] S_IDLE = 4'b0001;
    localparam [3:0] S_WAIT = 4'b0010;
    localparam [3:0] S_RUN  = 4'b0100;
    localparam [3:0] S_ACK  = 4'b1000;

    ////////////////////////////////////////////////////////////////////////////
    // state

    reg [3:0]  state_q;
    reg [1:0]  phase_q;
    reg [7:0]  acc_q;
    reg        zero_q;
    reg [6:0]  ptr_q;
    wire [7:0] latch_q;
    wire [7:0] oe_q;
    wire [7:0] pin_q;
    reg [11:0] op_q;
    reg [7:0]  operand_q;
    reg        ea_null_q;
    reg [4:0]  ea_low_q;
    reg [6:0]  ea_idx_q;
    reg        waitreq_q;
    reg [31:0] rdata_q;
    reg [7:0]  ram [0:`RAM_DEPTH-1];

    wire       cyc_start = (phase_q == 2'h0);
    wire       cyc_end   = (phase_q == `QCYC_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    // {null, low address} of an operand; zero pointer behind window is null
    function [5:0] eff_addr;
        input [4:0] f;
        input [6:0] ptr;
        reg   [4:0] low;
        begin
            low = (f == `FILE_WINDOW) ? ptr[4:0] : f;
            eff_addr = {(f == `FILE_WINDOW) && (low == `FILE_WINDOW), low};
        end
    endfunction

    // lower half shared by all banks, upper half banked
    function [6:0] ram_index;
        input [4:0] low;
        input [6:0] ptr;
        reg   [1:0] bank;
        begin
            bank = (BANKED != 0) ? ptr[6:5] : 2'b00;
            ram_index = low[4] ? (`RAM_BANK_BASE + {1'b0, bank, low[3:0]})
                               : {3'b000, low[3:0]};
        end
    endfunction

    localparam [1:0] KIND_RAM  = 2'h0;
    localparam [1:0] KIND_PTR  = 2'h1;
    localparam [1:0] KIND_PORT = 2'h2;

    // pointer and port sit in the file map but not in ram
    function [1:0] file_kind;
        input [4:0] low;
        begin
            if (low == `FILE_PTR) begin
                file_kind = KIND_PTR;
            end else if (low == `FILE_PORT) begin
                file_kind = KIND_PORT;
            end else begin
                file_kind = KIND_RAM;
            end
        end
    endfunction

    wire [7:0] ptr_read = {1'b1, ((BANKED != 0) ? ptr_q[6:5] : 2'b11), ptr_q[4:0]};

    wire [5:0] ea      = eff_addr(op_q[4:0], ptr_q);
    wire [6:0] ea_idx  = ram_index(ea[4:0], ptr_q);
    reg  [7:0] rd_val;

    always @* begin
        rd_val = 8'h00;
        if (ea[5]) begin
            rd_val = 8'h00;
        end else if (file_kind(ea[4:0]) == KIND_PTR) begin
            rd_val = ptr_read;
        end else if (file_kind(ea[4:0]) == KIND_PORT) begin
            rd_val = I_PORT_PIN;
        end else begin
            rd_val = ram[ea_idx];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // execution unit

    wire [7:0] result;
    wire       wr_w;
    wire       wr_f;
    wire       upd_z;
    wire       wr_dir;

    xor_bit_alu u_alu (
        .i_op      (op_q),
        .i_w       (acc_q),
        .i_operand (operand_q),
        .o_result  (result),
        .o_wr_w    (wr_w),
        .o_wr_f    (wr_f),
        .o_upd_z   (upd_z),
        .o_wr_dir  (wr_dir)
    );

    wire commit   = (state_q == S_RUN) && cyc_end;
    wire file_wr  = commit && wr_f && !ea_null_q;
    wire bus_req  = (state_q == S_IDLE) && waitreq_q && (I_READ || I_WRITE);
    wire bus_wr   = bus_req && I_WRITE && I_BYTEENABLE[0];
    wire is_instr = (I_ADDRESS == `REG_INSTR);
    wire fetch    = (state_q == S_WAIT) && cyc_start;
    wire port_wr  = file_wr && (file_kind(ea_low_q) == KIND_PORT);
    wire dir_wr   = commit && wr_dir;

    ////////////////////////////////////////////////////////////////////////////
    // register read mux

    reg  [31:0] reg_rdata;

    always @* begin
        reg_rdata = 32'h0000_0000;
        case (I_ADDRESS)
            `REG_ACC:   reg_rdata = {24'h000000, acc_q};
            `REG_STAT:  reg_rdata = {31'h0000000, zero_q};
            `REG_INSTR: reg_rdata = {20'h00000, op_q};
            `REG_PORT:  reg_rdata = {8'h00, ~oe_q, pin_q, latch_q};
            `REG_PTR:   reg_rdata = {24'h000000, ptr_read};
            default:    reg_rdata = 32'h0000_0000;
        endcase
    end

    // ram holds no reset, like ordinary data memory
    always @(posedge I_CLK_SYS) begin
        if (file_wr && (file_kind(ea_low_q) == KIND_RAM)) begin
            ram[ea_idx_q] <= result;
        end
    end

    // instruction cycle of four system clocks
    always @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            phase_q <= 2'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    always @(posedge I_CLK_SYS or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_q   <= S_IDLE;
            acc_q     <= `RST_ACC;
            zero_q    <= 1'b0;
            ptr_q     <= `RST_PTR;
            op_q      <= `RST_OP;
            operand_q <= 8'h00;
            ea_null_q <= 1'b0;
            ea_low_q  <= 5'h00;
            ea_idx_q  <= 7'h00;
            waitreq_q <= 1'b1;
            rdata_q   <= 32'h0000_0000;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (bus_req && I_WRITE && is_instr
                            && I_BYTEENABLE[1] && I_BYTEENABLE[0]) begin
                        // held off until a whole instruction cycle has run
                        op_q    <= I_WRITEDATA[11:0];
                        state_q <= S_WAIT;
                    end else if (bus_req) begin
                        if (bus_wr && (I_ADDRESS == `REG_ACC)) begin
                            acc_q <= I_WRITEDATA[7:0];
                        end
                        if (bus_wr && (I_ADDRESS == `REG_PTR)) begin
                            ptr_q <= {((PTR_W == 7) ? I_WRITEDATA[6:5] : 2'b00),
                                      I_WRITEDATA[4:0]};
                        end
                        rdata_q <= reg_rdata;
                        waitreq_q <= 1'b0;
                        state_q   <= S_ACK;
                    end
                end
                S_WAIT: begin
                    if (cyc_start) begin
                        operand_q <= rd_val;
                        ea_null_q <= ea[5];
                        ea_low_q  <= ea[4:0];
                        ea_idx_q  <= ea_idx;
                        state_q   <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (cyc_end) begin
                        if (wr_w) begin
                            acc_q <= result;
                        end
                        if (upd_z) begin
                            // flags move even when the file write is dropped
                            zero_q <= (result == 8'h00);
                        end
                        if (file_wr && (file_kind(ea_low_q) == KIND_PTR)) begin
                            ptr_q <= {((PTR_W == 7) ? result[6:5] : 2'b00), result[4:0]};
                        end
                        rdata_q   <= {24'h000000, result};
                        waitreq_q <= 1'b0;
                        state_q   <= S_ACK;
                    end
                end
                S_ACK: begin
                    waitreq_q <= 1'b1;
                    state_q   <= S_IDLE;
                end
                default: begin
                    waitreq_q <= 1'b1;
                    state_q   <= S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // port pins: sample, latch and direction flop per pin

    localparam [7:0] LATCH_RST = `RST_LATCH;
    localparam [7:0] OE_RST    = `RST_OE;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_pin
            reg pin_bit_q;
            reg latch_bit_q;
            reg oe_bit_q;

            // pin taken once at fetch, so a late edge cannot leak in
            always @(posedge I_CLK_SYS or negedge I_RESETN) begin
                if (!I_RESETN) begin
                    pin_bit_q   <= 1'b0;
                    latch_bit_q <= LATCH_RST[g];
                    oe_bit_q    <= OE_RST[g];
                end else begin
                    if (fetch) begin
                        pin_bit_q <= I_PORT_PIN[g];
                    end
                    if (port_wr) begin
                        latch_bit_q <= result[g];
                    end
                    if (dir_wr) begin
                        oe_bit_q <= ~result[g];
                    end
                end
            end

            assign pin_q[g]   = pin_bit_q;
            assign latch_q[g] = latch_bit_q;
            assign oe_q[g]    = oe_bit_q;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign O_READDATA    = rdata_q;
    assign O_WAITREQUEST = waitreq_q;
    assign O_PORT_OUT    = latch_q;
    assign O_PORT_OE     = oe_q;

endmodule // indirect_file_access_xor

/* ifa_consts.vh */
// constants for the indirect file access and exclusive-or block
`ifndef IFA_CONSTS_VH
`define IFA_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// bus register byte addresses
`define REG_ACC        5'h00
`define REG_STAT       5'h04
`define REG_INSTR      5'h08
`define REG_PORT       5'h0C
`define REG_PTR        5'h10

////////////////////////////////////////////////////////////////////////////////
// data memory map
`define FILE_WINDOW    5'h00
`define FILE_PTR       5'h04
`define FILE_PORT      5'h06
`define RAM_DEPTH      80
`define RAM_BANK_BASE  7'h10

////////////////////////////////////////////////////////////////////////////////
// opcodes
`define OP_XOR_LIT_HI  4'hF
`define OP_XOR_FILE_HI 6'h06
`define OP_BIT_CLR_HI  4'h4
`define OP_BIT_SET_HI  4'h5
`define OP_MOVE_W_HI   7'h01
`define OP_DIRLOAD     12'h006

////////////////////////////////////////////////////////////////////////////////
// reset values and timing
`define RST_ACC        8'h00
`define RST_PTR        7'h00
`define RST_LATCH      8'h00
`define RST_OE         8'h00
`define RST_OP         12'h000
`define QCYC_LAST      2'h3

`endif

/* xor_bit_alu.v */
// instruction decode and result path for xor, bit and move operations
`include "ifa_consts.vh"

module xor_bit_alu (
    input  wire [11:0] i_op,
    input  wire [7:0]  i_w,
    input  wire [7:0]  i_operand,
    output reg  [7:0]  o_result,
    output reg         o_wr_w,
    output reg         o_wr_f,
    output reg         o_upd_z,
    output reg         o_wr_dir
);

    wire [7:0] bit_mask = 8'h01 << i_op[7:5];

    always @* begin
        o_result = 8'h00;
        o_wr_w   = 1'b0;
        o_wr_f   = 1'b0;
        o_upd_z  = 1'b0;
        o_wr_dir = 1'b0;
        if (i_op[11:8] == `OP_XOR_LIT_HI) begin
            o_result = i_w ^ i_op[7:0];
            o_wr_w   = 1'b1;
            o_upd_z  = 1'b1;
        end else if (i_op[11:6] == `OP_XOR_FILE_HI) begin
            o_result = i_w ^ i_operand;
            o_wr_f   = i_op[5];
            o_wr_w   = ~i_op[5];
            o_upd_z  = 1'b1;
        end else if (i_op[11:8] == `OP_BIT_CLR_HI) begin
            // whole operand goes back, so input pins land in the latch
            o_result = i_operand & ~bit_mask;
            o_wr_f   = 1'b1;
        end else if (i_op[11:8] == `OP_BIT_SET_HI) begin
            o_result = i_operand | bit_mask;
            o_wr_f   = 1'b1;
        end else if (i_op[11:5] == `OP_MOVE_W_HI) begin
            o_result = i_w;
            o_wr_f   = 1'b1;
        end else if (i_op == `OP_DIRLOAD) begin
            o_result = i_w;
            o_wr_dir = 1'b1;
        end
    end

endmodule // xor_bit_alu

/* ifa_checker_asserts.sv */
// bus timing and port commit checks for the indirect access block
module ifa_checker #(
    parameter BANKED = 1
) (
    input wire        I_CLK_SYS,
    input wire        I_RESETN,
    input wire [4:0]  I_ADDRESS,
    input wire        I_READ,
    input wire        I_WRITE,
    input wire [31:0] I_WRITEDATA,
    input wire [3:0]  I_BYTEENABLE,
    input wire [31:0] O_READDATA,
    input wire        O_WAITREQUEST,
    input wire [7:0]  I_PORT_PIN,
    input wire [7:0]  O_PORT_OUT,
    input wire [7:0]  O_PORT_OE
);
    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RESETN);
    a_wait_pulse: assert property (!O_WAITREQUEST |=> O_WAITREQUEST)
        else $error("answer held over one cycle");
    a_read_answer: assert property ($rose(I_READ) |=> !O_WAITREQUEST)
        else $error("read answer late");
    a_plain_write: assert property ($rose(I_WRITE) && I_ADDRESS != 5'h08 |=> !O_WAITREQUEST)
        else $error("register write answer late");
    // instruction needs one whole instruction cycle
    a_instr_time: assert property ($rose(I_WRITE) && I_ADDRESS == 5'h08
        && I_BYTEENABLE[1:0] == 2'h3
        |=> O_WAITREQUEST[*4] ##[1:5] !O_WAITREQUEST) else $error("instruction timing");
    a_port_commit: assert property ($changed(O_PORT_OUT) |-> !O_WAITREQUEST)
        else $error("port latch moved off commit");
    a_dir_commit: assert property ($changed(O_PORT_OE) |-> !O_WAITREQUEST)
        else $error("direction moved off commit");
    a_rdata_hold: assert property (O_WAITREQUEST |-> $stable(O_READDATA))
        else $error("read data moved while waiting");
    a_ptr_width: assert property (!O_WAITREQUEST && I_READ && I_ADDRESS == 5'h10
        |-> (BANKED ? O_READDATA[31:7] == 25'h1 : O_READDATA[31:5] == 27'h7))
        else $error("pointer upper bits wrong");
    a_stat_bits: assert property (!O_WAITREQUEST && I_READ && I_ADDRESS == 5'h04
        |-> O_READDATA[31:1] == 31'h0) else $error("status has extra bits");
    cover property ($rose(I_WRITE) && I_ADDRESS == 5'h08);
    cover property ($changed(O_PORT_OUT));
    cover property (!O_WAITREQUEST && I_READ && I_ADDRESS == 5'h04 && O_READDATA[0]);
endmodule // ifa_checker

bind indirect_file_access_xor ifa_checker #(.BANKED(BANKED)) u_chk (
    .I_CLK_SYS(I_CLK_SYS), .I_RESETN(I_RESETN), .I_ADDRESS(I_ADDRESS),
    .I_READ(I_READ), .I_WRITE(I_WRITE), .I_WRITEDATA(I_WRITEDATA),
    .I_BYTEENABLE(I_BYTEENABLE), .O_READDATA(O_READDATA),
    .O_WAITREQUEST(O_WAITREQUEST), .I_PORT_PIN(I_PORT_PIN),
    .O_PORT_OUT(O_PORT_OUT), .O_PORT_OE(O_PORT_OE));

/* testbench.sv */
// bus-driven test sequence for the indirect access block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst_n = 0, rd = 0, wr = 0;
    logic [4:0]  adr = 0;
    logic [31:0] wd = 0, rdat, rdat_flat;
    wire  [31:0] rdata_flat;
    logic [7:0]  pins = 8'hC5;
    wire  [31:0] rdata;
    wire         waitreq;
    wire  [7:0]  port_out, port_oe;
    int          errors = 0, tests_run = 0;
    always #2.5 clk = ~clk;
    indirect_file_access_xor dut (.I_CLK_SYS(clk), .I_RESETN(rst_n), .I_ADDRESS(adr),
        .I_READ(rd), .I_WRITE(wr), .I_WRITEDATA(wd), .I_BYTEENABLE(4'hF),
        .O_READDATA(rdata), .O_WAITREQUEST(waitreq), .I_PORT_PIN(pins),
        .O_PORT_OUT(port_out), .O_PORT_OE(port_oe));
    // unbanked build on the same bus, to see the five-bit pointer
    indirect_file_access_xor #(.BANKED(0)) dut_flat (.I_CLK_SYS(clk), .I_RESETN(rst_n),
        .I_ADDRESS(adr), .I_READ(rd), .I_WRITE(wr), .I_WRITEDATA(wd), .I_BYTEENABLE(4'hF),
        .O_READDATA(rdata_flat), .O_WAITREQUEST(), .I_PORT_PIN(pins),
        .O_PORT_OUT(), .O_PORT_OE());
    ////////////////////////////////////////////////////////////////////////////////
    task stop_test;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // request held until the edge that sees waitrequest low
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w; wr <= w; adr <= a; wd <= d;
        do begin @(posedge clk); n++; end while (waitreq !== 1'b0 && n < 50);
        if (n >= 50) chk(32'h0, 32'h1);
        rdat = rdata;
        rdat_flat = rdata_flat;
        rd <= 0; wr <= 0;
    endtask
    task rchk(input logic [4:0] a, input logic [31:0] e);
        bus(0, a, 32'h0); chk(rdat, e);
    endtask
    task op(input logic [11:0] c); bus(1, 5'h08, {20'h0, c}); endtask
    task seta(input logic [7:0] v); bus(1, 5'h00, {24'h0, v}); endtask
    task setp(input logic [7:0] v); bus(1, 5'h10, {24'h0, v}); endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1;
        rchk(5'h10, 32'h80);
        chk(rdat_flat, 32'hE0);
        chk({24'h0, port_oe}, 32'h0);
        bus(1, 5'h14, 32'hFF); rchk(5'h14, 32'h0);
        $display("test reset done");
        seta(8'hB5); op(12'hFAF); rchk(5'h00, 32'h1A);
        rchk(5'h04, 32'h0);
        op(12'hF1A); rchk(5'h00, 32'h0);
        rchk(5'h04, 32'h1);
        $display("test literal done");
        seta(8'h10); op(12'h028); seta(8'h0A); op(12'h029);
        setp(8'h08); seta(8'h00); op(12'h180); rchk(5'h00, 32'h10);
        setp(8'h09); op(12'h180); rchk(5'h00, 32'h1A);
        seta(8'hB5); op(12'h1A8); rchk(5'h00, 32'hB5);
        seta(8'h00); op(12'h188); rchk(5'h00, 32'hA5);
        $display("test indirect done");
        setp(8'h00); seta(8'h55); op(12'h180); rchk(5'h00, 32'h55);
        rchk(5'h04, 32'h0);
        seta(8'h00); op(12'h1A0); rchk(5'h04, 32'h1);
        rchk(5'h10, 32'h80);
        $display("test self window done");
        // same low address in every bank must stay apart
        for (int i = 0; i < 4; i++) begin
            setp({1'b0, 2'(i), 5'h10}); seta(8'h40 + 8'(i)); op(12'h020);
        end
        for (int i = 0; i < 4; i++) begin
            setp({1'b0, 2'(i), 5'h10}); seta(8'h00); op(12'h180);
            rchk(5'h00, {24'h0, 8'h40 + 8'(i)});
            rchk(5'h10, {24'h0, 1'b1, 2'(i), 5'h10});
            chk(rdat_flat, 32'hF0);
        end
        $display("test banks done");
        seta(8'hF0); op(12'h006); chk({24'h0, port_oe}, 32'h0F);
        op(12'h506); chk({24'h0, port_out}, 32'hC5);
        pins <= 8'h3A;
        op(12'h4E6); chk({24'h0, port_out}, 32'h3A);
        rchk(5'h0C, 32'h00F03A3A);
        rchk(5'h08, 32'h000004E6);
        $display("test port done");
        stop_test;
    end
    initial begin
        #100000;
        errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        stop_test;
    end
endmodule // testbench
